// file: dcbm_cfg.svh
// Offsets, field positions, reset values and counts for the data cache bus miss control
`ifndef DCBM_CFG_SVH
`define DCBM_CFG_SVH
`define DCBM_CTRL_OFF   12'h000
`define DCBM_STAT_OFF   12'h004
`define DCBM_FILLS_OFF  12'h008
`define DCBM_CASTS_OFF  12'h00C
`define DCBM_PUSHES_OFF 12'h010
`define DCBM_CTRL_RST   4'h0
`define DCBM_CTRL_DCE   0
`define DCBM_CTRL_BUS32 1
`define DCBM_CTRL_DXL   2
`define DCBM_CTRL_IXL   3
`define DCBM_ATTR_W     3
`define DCBM_ATTR_I     2
`define DCBM_ATTR_M     1
`define DCBM_ATTR_G     0
`define DCBM_ATTR_REAL  4'h3
`define DCBM_BEATS64    4'h4
`define DCBM_BEATS32    4'h8
`define DCBM_BEAT_BYTES 4'h8
`define DCBM_AGE_LRU    2'h3
`endif

// file: dcbm_pkg.sv
// Types shared by the data cache bus miss control
package dcbm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} dcbm_state_type;
  typedef enum logic [2:0] {OP_RD1, OP_WR1, OP_FILL, OP_CAST, OP_PUSH} dcbm_op_type;
  // Access from the load/store side; only misses, write-through and uncached ones need the bus
  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [3:0]  size;
    logic        is_store;
    logic        is_instr;
    logic        from_instr_block_translation_pair;
    logic        direct_store;
    logic [3:0]  storage_attribute_bits;
    logic        hit;
    logic [1:0]  hit_way;
  } dcbm_req_type;
  // State of the addressed set as the array reports it
  typedef struct packed {
    logic [3:0]       valid;
    logic [3:0]       dirty;
    logic [3:0][1:0]  age;
    logic [3:0][19:0] tag;
  } dcbm_set_type;
  // Address tenure presented on the system bus
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  size;
    logic        write;
    logic        burst_transfer_indicator;
    logic        global;
    logic        hipri;
  } dcbm_bus_type;
endpackage

// file: dcbm_ctrl.sv
// Data cache bus miss control: fills, cast-outs, pushes, single beats, attribute decode
`timescale 1ns/1ps
`default_nettype none
`include "dcbm_cfg.svh"
module dcbm_ctrl
  import dcbm_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         req_valid,
  input  wire dcbm_req_type req,
  output logic              req_ready,
  input  wire dcbm_set_type set_info,
  output logic              req_done,
  output logic              dsi_exception,
  output logic [63:0]       ld_data,
  input  wire logic         push_valid,
  input  wire logic [31:0]  push_addr,
  input  wire logic [1:0]   push_way,
  input  wire logic         push_hipri,
  output logic              push_ready,
  output logic              cache_wr_en,
  output logic [1:0]        cache_wr_way,
  output logic [2:0]        cache_wr_word,
  output logic              cache_wr_dbl,
  output logic [63:0]       cache_wr_data,
  output logic [1:0]        cache_rd_way,
  output logic [1:0]        cache_rd_dw,
  input  wire logic [63:0]  cache_rd_data,
  output logic              bus_addr_valid,
  output dcbm_bus_type      bus_out,
  input  wire logic         bus_addr_ack,
  input  wire logic         snoop_retry_response,
  input  wire logic         bus_ta,
  input  wire logic [63:0]  bus_rdata,
  output logic [63:0]       bus_wdata
);

  // Way whose age marks it least recently used
  function automatic logic [1:0] lru_way(input logic [3:0][1:0] age);
    lru_way = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (age[i] == `DCBM_AGE_LRU) begin
        lru_way = i[1:0];
      end
    end
  endfunction

  // Effective attributes for the access type
  function automatic logic [3:0] eff_attr(input dcbm_req_type r, input logic dxl, input logic ixl);
    logic [3:0] a;
    a = (r.is_instr ? ixl : dxl) ? r.storage_attribute_bits : `DCBM_ATTR_REAL;
    if (r.from_instr_block_translation_pair) begin
      a[`DCBM_ATTR_G] = 1'b0;
    end
    eff_attr = a;
  endfunction

  dcbm_state_type state_r;
  dcbm_op_type    op_r;
  logic           fill_pend_r;
  logic [3:0]     ctrl_r;
  logic [3:0]     attr_r;
  logic [31:0]    addr_r;
  logic [1:0]     way_r;
  logic [3:0]     beat_r;
  logic [31:0]    fills_r;
  logic [31:0]    casts_r;
  logic [31:0]    pushes_r;
  logic           take_req;
  logic [3:0]     attr_nxt;
  logic           single_nxt;
  logic [1:0]     vict_nxt;
  logic           vict_dirty;
  logic           is_burst;
  logic [3:0]     beat_lim;
  logic           last_beat;
  logic [2:0]     word_idx;
  logic [3:0]     rd_beat;
  logic [2:0]     rd_word;

  // Requests wait while a push is pending so snoop data leaves first
  assign push_ready = (state_r == ST_IDLE);
  assign req_ready  = (state_r == ST_IDLE) && !push_valid;
  assign take_req   = req_valid && req_ready;
  assign attr_nxt   = eff_attr(req, ctrl_r[`DCBM_CTRL_DXL], ctrl_r[`DCBM_CTRL_IXL]);
  assign single_nxt = !ctrl_r[`DCBM_CTRL_DCE] || attr_nxt[`DCBM_ATTR_I] ||
                      (req.is_store && attr_nxt[`DCBM_ATTR_W]);
  assign vict_nxt   = lru_way(set_info.age);
  assign vict_dirty = set_info.valid[vict_nxt] && set_info.dirty[vict_nxt];

  // Beat bookkeeping; bus width is sampled live, so change it only when idle
  assign is_burst  = (op_r == OP_FILL) || (op_r == OP_CAST) || (op_r == OP_PUSH);
  assign beat_lim  = !is_burst ? 4'h1 :
                     ctrl_r[`DCBM_CTRL_BUS32] ? `DCBM_BEATS32 : `DCBM_BEATS64;
  assign last_beat = (beat_r == beat_lim - 4'h1);
  // Fill starts at the critical double word and wraps; others start at word zero
  assign word_idx = ((op_r == OP_FILL) ? {addr_r[4:3], 1'b0} : 3'h0) +
                    (ctrl_r[`DCBM_CTRL_BUS32] ? beat_r[2:0] : {beat_r[1:0], 1'b0});
  // Read ahead one beat so write data is ready on back-to-back acknowledges
  assign rd_beat = beat_r + ((state_r == ST_DATA && bus_ta) ? 4'h1 : 4'h0);
  assign rd_word = (ctrl_r[`DCBM_CTRL_BUS32] ? rd_beat[2:0] : {rd_beat[1:0], 1'b0});
  assign cache_rd_way   = way_r;
  assign cache_rd_dw    = rd_word[2:1];
  assign bus_addr_valid = (state_r == ST_ADDR);

  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      op_r        <= OP_RD1;
      fill_pend_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (push_valid) begin
            op_r    <= OP_PUSH;
            state_r <= ST_ADDR;
          end else if (take_req && !req.direct_store) begin
            if (single_nxt) begin
              op_r    <= req.is_store ? OP_WR1 : OP_RD1;
              state_r <= ST_ADDR;
            end else if (!req.hit) begin
              op_r        <= vict_dirty ? OP_CAST : OP_FILL;
              fill_pend_r <= vict_dirty;
              state_r     <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          // A retried tenure is presented again; the snooper flushes meanwhile
          if (bus_addr_ack && !snoop_retry_response) begin
            state_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bus_ta && last_beat) begin
            if (fill_pend_r) begin
              op_r        <= OP_FILL;
              fill_pend_r <= 1'b0;
              state_r     <= ST_ADDR;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Captured access, attributes and victim
  always_ff @(posedge mclk) begin
    if (rst) begin
      attr_r <= 4'h0;
      addr_r <= 32'h0000_0000;
      way_r  <= 2'h0;
    end else if (state_r == ST_IDLE && push_valid) begin
      addr_r <= push_addr;
      way_r  <= push_way;
    end else if (take_req) begin
      attr_r <= attr_nxt;
      addr_r <= req.addr;
      way_r  <= req.hit ? req.hit_way : vict_nxt;
    end
  end

  // Beat counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      beat_r <= 4'h0;
    end else if (state_r != ST_DATA) begin
      beat_r <= 4'h0;
    end else if (bus_ta) begin
      beat_r <= last_beat ? 4'h0 : beat_r + 4'h1;
    end
  end

  // Address tenure contents
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_out <= '0;
    end else if (state_r == ST_IDLE && push_valid) begin
      bus_out.addr  <= {push_addr[31:5], 5'h00};
      bus_out.size  <= `DCBM_BEAT_BYTES;
      bus_out.write <= 1'b1;
      bus_out.burst_transfer_indicator <= 1'b1;
      bus_out.global <= 1'b1;
      bus_out.hipri  <= push_hipri;
    end else if (take_req) begin
      bus_out.addr  <= single_nxt ? req.addr : {req.addr[31:3], 3'h0};
      bus_out.size  <= single_nxt ? req.size : `DCBM_BEAT_BYTES;
      bus_out.write <= single_nxt && req.is_store;
      bus_out.burst_transfer_indicator <= !single_nxt;
      bus_out.global <= attr_nxt[`DCBM_ATTR_M];
      bus_out.hipri  <= 1'b0;
      if (!single_nxt && vict_dirty) begin
        bus_out.addr  <= {set_info.tag[vict_nxt], req.addr[11:5], 5'h00};
        bus_out.write <= 1'b1;
      end
    end else if (state_r == ST_DATA && bus_ta && last_beat && fill_pend_r) begin
      bus_out.addr  <= {addr_r[31:3], 3'h0};
      bus_out.write <= 1'b0;
      bus_out.global <= attr_r[`DCBM_ATTR_M];
    end
  end

  // Outgoing data: store data for singles, cache words for cast-out and push
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_wdata <= 64'h0;
    end else if (take_req) begin
      bus_wdata <= req.wdata;
    end else if (op_r == OP_CAST || op_r == OP_PUSH) begin
      bus_wdata <= !ctrl_r[`DCBM_CTRL_BUS32] ? cache_rd_data :
                   {32'h0, rd_word[0] ? cache_rd_data[31:0] : cache_rd_data[63:32]};
    end
  end

  // Cache write port: fill beats, and store hits that stay or also go out
  always_ff @(posedge mclk) begin
    if (rst) begin
      cache_wr_en   <= 1'b0;
      cache_wr_way  <= 2'h0;
      cache_wr_word <= 3'h0;
      cache_wr_dbl  <= 1'b0;
      cache_wr_data <= 64'h0;
    end else if (state_r == ST_DATA && bus_ta && op_r == OP_FILL) begin
      cache_wr_en   <= 1'b1;
      cache_wr_way  <= way_r;
      cache_wr_word <= word_idx;
      cache_wr_dbl  <= !ctrl_r[`DCBM_CTRL_BUS32];
      cache_wr_data <= ctrl_r[`DCBM_CTRL_BUS32] ? {bus_rdata[31:0], 32'h0} : bus_rdata;
    end else begin
      cache_wr_en   <= take_req && req.is_store && req.hit && !req.direct_store &&
                       ctrl_r[`DCBM_CTRL_DCE] && !attr_nxt[`DCBM_ATTR_I];
      cache_wr_way  <= req.hit_way;
      cache_wr_word <= req.addr[4:2];
      cache_wr_dbl  <= 1'b1;
      cache_wr_data <= req.wdata;
    end
  end

  // Completion, exception and load data
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_done      <= 1'b0;
      dsi_exception <= 1'b0;
      ld_data       <= 64'h0;
    end else begin
      dsi_exception <= take_req && req.direct_store;
      req_done <= (take_req && !req.direct_store && !single_nxt && req.hit) ||
                  (state_r == ST_DATA && bus_ta && last_beat && !fill_pend_r && op_r != OP_PUSH);
      if (state_r == ST_DATA && bus_ta && op_r == OP_RD1) begin
        ld_data <= bus_rdata;
      end
    end
  end

  // Activity counters, visible to software
  always_ff @(posedge mclk) begin
    if (rst) begin
      fills_r  <= 32'h0;
      casts_r  <= 32'h0;
      pushes_r <= 32'h0;
    end else if (state_r == ST_DATA && bus_ta && last_beat) begin
      fills_r  <= fills_r + {31'h0, op_r == OP_FILL};
      casts_r  <= casts_r + {31'h0, op_r == OP_CAST};
      pushes_r <= pushes_r + {31'h0, op_r == OP_PUSH};
    end
  end

  // APB slave, zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      `DCBM_CTRL_OFF:   prdata = {28'h0, ctrl_r};
      `DCBM_STAT_OFF:   prdata = {20'h0, attr_r, fill_pend_r, op_r, 2'h0, state_r};
      `DCBM_FILLS_OFF:  prdata = fills_r;
      `DCBM_CASTS_OFF:  prdata = casts_r;
      `DCBM_PUSHES_OFF: prdata = pushes_r;
      default:          pslverr = psel && penable;
    endcase
  end

  // Control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `DCBM_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `DCBM_CTRL_OFF) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_fill_align:   assert property (bus_addr_valid && op_r == OP_FILL |-> bus_out.addr[2:0] == 3'h0)
    else $error("fill address not double-word aligned");
  chk_block_align:  assert property (bus_addr_valid && (op_r == OP_CAST || op_r == OP_PUSH)
                      |-> bus_out.addr[4:0] == 5'h00 && bus_out.write)
    else $error("cast-out or push not block aligned");
  chk_burst_flag:   assert property (bus_addr_valid |-> bus_out.burst_transfer_indicator == is_burst)
    else $error("burst indicator wrong");
  chk_global_attr:  assert property (bus_addr_valid && !is_burst |-> bus_out.global == attr_r[`DCBM_ATTR_M])
    else $error("global marking differs from coherency attribute");
  chk_dsi_nobus:    assert property (take_req && req.direct_store |=> dsi_exception && state_r == ST_IDLE)
    else $error("direct-store access reached the bus");
  chk_real_attr:    assert property (take_req && !ctrl_r[`DCBM_CTRL_DXL] && !req.is_instr
                      |=> attr_r == `DCBM_ATTR_REAL)
    else $error("real-mode attributes not applied");
  chk_crit_first:   assert property (state_r == ST_DATA && op_r == OP_FILL && bus_ta && beat_r == 4'h0
                      |=> cache_wr_en && cache_wr_word == {addr_r[4:3], 1'b0})
    else $error("fill did not start at critical double word");
  chk_beat_count:   assert property (state_r == ST_DATA && bus_ta && last_beat && !fill_pend_r
                      |=> state_r == ST_IDLE)
    else $error("transfer did not end on its last beat");
  chk_clean_victim: assert property (take_req && !req.direct_store && !single_nxt && !req.hit && !vict_dirty
                      |=> op_r == OP_FILL && !fill_pend_r)
    else $error("clean victim was cast out");
  chk_wt_single:    assert property (take_req && !req.direct_store && req.is_store && single_nxt
                      |=> op_r == OP_WR1 && bus_addr_valid)
    else $error("write-through store not sent as single beat");
  // Snoop data must leave ahead of any waiting request
  chk_push_first:   assert property (push_valid && state_r == ST_IDLE |=> op_r == OP_PUSH && bus_addr_valid)
    else $error("push not started from idle");
  chk_cast_fill:    assert property (state_r == ST_DATA && op_r == OP_CAST && bus_ta && last_beat
                      |=> op_r == OP_FILL && bus_addr_valid)
    else $error("cast-out not followed by its fill");

  cov_castout_fill: cover property (state_r == ST_DATA && op_r == OP_CAST ##[1:40] op_r == OP_FILL);
  cov_push:         cover property (state_r == ST_DATA && op_r == OP_PUSH && bus_ta && last_beat);
  cov_retry:        cover property (bus_addr_valid && bus_addr_ack && snoop_retry_response);
  cov_dsi:          cover property (dsi_exception);
  cov_bus32_fill:   cover property (state_r == ST_DATA && op_r == OP_FILL && ctrl_r[`DCBM_CTRL_BUS32] && bus_ta && beat_r == 4'h7);

endmodule // dcbm_ctrl
`default_nettype wire

// file: dcbm_bus_model.sv
// Behavioural system bus: address acknowledge with optional retry, then data beats
`timescale 1ns/1ps
`default_nettype none
module dcbm_bus_model
  import dcbm_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         bus_addr_valid,
  input  wire dcbm_bus_type bus_out,
  input  wire logic         bus32,
  input  wire logic         retry_en,
  input  wire logic         slow,
  output logic              bus_addr_ack,
  output logic              snoop_retry_response,
  output logic              bus_ta,
  output logic [63:0]       bus_rdata
);
  logic [1:0] st_r;
  logic [3:0] left_r;
  logic       retried_r;
  logic       go;
  // One tenure at a time; slow mode leaves random gaps before ack and between beats
  always @(posedge mclk) begin
    go = !slow || ($random % 2 != 0);
    // Data lines change every cycle so stale data never looks valid
    bus_rdata <= {$random, $random};
    if (rst) begin
      st_r <= 2'h0;
      bus_addr_ack <= 1'b0;
      snoop_retry_response <= 1'b0;
      bus_ta <= 1'b0;
      retried_r <= 1'b0;
    end else begin
      case (st_r)
        2'h0: if (bus_addr_valid && go) begin
          bus_addr_ack <= 1'b1;
          snoop_retry_response <= retry_en && !retried_r;
          retried_r <= retry_en;
          st_r <= 2'h1;
        end
        2'h1: begin
          bus_addr_ack <= 1'b0;
          snoop_retry_response <= 1'b0;
          left_r <= bus_out.burst_transfer_indicator ? (bus32 ? 4'h8 : 4'h4) : 4'h1;
          st_r <= snoop_retry_response ? 2'h0 : 2'h2;
        end
        default: begin
          if (bus_ta) left_r <= left_r - 4'h1;
          if (bus_ta && left_r == 4'h1) begin
            bus_ta <= 1'b0;
            retried_r <= 1'b0;
            st_r <= 2'h0;
          end else bus_ta <= go;
        end
      endcase
    end
  end
endmodule // dcbm_bus_model
`default_nettype wire

// file: data_cache_bus_miss_control_bench.sv
// Self-checking bench for the data cache bus miss control
`timescale 1ns/1ps
`default_nettype none
`include "dcbm_cfg.svh"
module data_cache_bus_miss_control_bench;
  import dcbm_pkg::*;
  logic         mclk, rst, psel, penable, pwrite, req_valid, push_valid, push_hipri;
  logic         b32, retry_en, slow, pready, pslverr, req_ready, req_done, dsi_exception;
  logic         push_ready, cache_wr_en, bus_addr_valid, bus_addr_ack, snoop_retry_response, bus_ta;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, push_addr, q, pa;
  logic [1:0]   push_way, v;
  logic [2:0]   cache_wr_word;
  logic [63:0]  bus_rdata, crd, ld_data, bus_wdata, lx, wx;
  logic [3:0]   c, at;
  logic         e, one, cast, ph;
  dcbm_req_type req, r;
  dcbm_set_type set_info, s;
  dcbm_bus_type bus_out, f;
  dcbm_bus_type tq[$];
  logic [2:0]   wq[$];
  int           n_fail, total_checks, seed, i, k, n, bt, nf, nc;
  dcbm_ctrl dcbm_ctrl_inst (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req, .req_ready, .set_info, .req_done, .dsi_exception, .ld_data,
    .push_valid, .push_addr, .push_way, .push_hipri, .push_ready, .cache_wr_en, .cache_wr_way(),
    .cache_wr_word, .cache_wr_dbl(), .cache_wr_data(), .cache_rd_way(), .cache_rd_dw(),
    .cache_rd_data(crd), .bus_addr_valid, .bus_out, .bus_addr_ack, .snoop_retry_response, .bus_ta,
    .bus_rdata, .bus_wdata);
  dcbm_bus_model dcbm_bus_model_inst (.mclk, .rst, .bus_addr_valid, .bus_out, .bus32(b32), .retry_en,
    .slow, .bus_addr_ack, .snoop_retry_response, .bus_ta, .bus_rdata);
  // Accepted tenures and cache writes, as seen at the edge
  always @(posedge mclk) begin
    if (bus_addr_valid && bus_addr_ack && !snoop_retry_response) tq.push_back(bus_out);
    if (cache_wr_en) wq.push_back(cache_wr_word);
    // Last beat's data in both directions, as the edge saw it
    if (bus_ta) begin
      lx <= bus_rdata;
      wx <= bus_wdata;
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // APB master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Request held until taken; n counts cycles to completion
  task automatic do_req;
    tq.delete();
    wq.delete();
    @(posedge mclk);
    req <= r;
    set_info <= s;
    req_valid <= 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = -1;
    do begin
      @(negedge mclk);
      n++;
    end while (req_done !== 1'b1 && dsi_exception !== 1'b1);
    // One more edge so the last cache write reaches the log
    @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  initial begin
    {rst, psel, penable, pwrite, req_valid, push_valid, push_hipri, b32, retry_en, slow} = 10'h200;
    {paddr, pwdata, push_addr, push_way, req, set_info} = '0;
    crd = 64'h0123456789ABCDEF;
    seed = 40;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, `DCBM_CTRL_OFF, 32'h0);
    chk(q, `DCBM_CTRL_RST);
    chk(e, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk(e, 1'b1);
    for (i = 0; i < 120; i++) begin
      // First four: dirty-victim fills at every critical double word
      c = (i < 4) ? {2'b01, i[0], 1'b1} : 4'($random(seed));
      apb(1'b1, `DCBM_CTRL_OFF, {28'h0, c});
      apb(1'b0, `DCBM_CTRL_OFF, 32'h0);
      chk(q, {28'h0, c});
      b32 <= c[1];
      retry_en <= 1'($random(seed));
      slow <= 1'($random(seed));
      r.addr = $random(seed);
      r.wdata = {$random(seed), $random(seed)};
      {r.is_store, r.hit, r.hit_way, r.storage_attribute_bits} = 8'($random(seed));
      r.size = 4'h1 + 4'($random(seed) & 7);
      r.is_instr = ($random(seed) & 3) == 0;
      r.from_instr_block_translation_pair = r.is_instr && c[3] && $random(seed) % 2 != 0;
      r.direct_store = ($random(seed) & 7) == 0;
      v = 2'($random(seed));
      s = {$random(seed), $random(seed), $random(seed)};
      s.age = '0;
      s.age[v] = `DCBM_AGE_LRU;
      if (i < 4) begin
        {r.direct_store, r.hit, r.is_instr, r.from_instr_block_translation_pair, r.storage_attribute_bits} = 8'h0;
        r.addr[4:3] = 2'(i);
        {s.valid, s.dirty} = 8'hFF;
      end
      do_req();
      at = (r.is_instr ? c[3] : c[2]) ? r.storage_attribute_bits : `DCBM_ATTR_REAL;
      if (r.from_instr_block_translation_pair) at[`DCBM_ATTR_G] = 1'b0;
      apb(1'b0, `DCBM_STAT_OFF, 32'h0);
      chk(q[11:8], at);
      one = !c[0] || at[2] || (r.is_store && at[3]);
      bt = c[1] ? 8 : 4;
      cast = s.valid[v] && s.dirty[v];
      if (r.direct_store) begin
        chk({n, tq.size()}, 0);
      end else if (one) begin
        chk(tq.size(), 1);
        chk({tq[0].burst_transfer_indicator, tq[0].write, tq[0].addr}, {1'b0, r.is_store, r.addr});
        chk(tq[0].global, at[1]);
        chk(wq.size(), r.is_store && r.hit && c[0] && !at[2]);
        if (r.is_store) chk(wx, r.wdata);
        else chk(ld_data, lx);
      end else if (r.hit) begin
        chk({n[15:0], 16'(tq.size()), 32'(wq.size())}, {32'h0, 31'h0, r.is_store});
      end else begin
        nf++;
        nc += cast;
        chk(tq.size(), 1 + cast);
        if (cast) chk({tq[0].burst_transfer_indicator, tq[0].write, tq[0].addr},
                      {2'b11, s.tag[v], r.addr[11:5], 5'h0});
        f = tq[cast];
        chk({f.burst_transfer_indicator, f.write, f.addr}, {2'b10, r.addr[31:3], 3'h0});
        chk(f.global, at[1]);
        for (k = 0; k < bt; k++) chk(wq[k], 3'(r.addr[4:3] * 2 + k * (c[1] ? 1 : 2)));
        chk(wq.size(), bt);
      end
    end
    for (i = 0; i < 4; i++) begin
      tq.delete();
      pa = $random(seed);
      ph = i[0];
      @(posedge mclk);
      push_valid <= 1'b1;
      push_addr <= pa;
      push_hipri <= ph;
      push_way <= 2'(i);
      do @(posedge mclk); while (push_ready !== 1'b1);
      push_valid <= 1'b0;
      do @(negedge mclk); while (tq.size() == 0 || push_ready !== 1'b1);
      chk({tq[0].write, tq[0].burst_transfer_indicator, tq[0].addr}, {2'b11, pa[31:5], 5'h0});
      chk({tq[0].hipri, tq[0].global}, {ph, 1'b1});
    end
    // Activity counters against the bench's own tally
    apb(1'b0, `DCBM_FILLS_OFF, 32'h0);
    chk(q, nf);
    apb(1'b0, `DCBM_CASTS_OFF, 32'h0);
    chk(q, nc);
    apb(1'b0, `DCBM_PUSHES_OFF, 32'h0);
    chk(q, 4);
    end_sim();
  end
endmodule // data_cache_bus_miss_control_bench
`default_nettype wire
